// ### design/hdc_regs.sv
// hdc_regs: byte-addressed descriptor configuration bank with a descriptor read port.
// assumes: one synchronous master on the register port; the descriptor engine reads
// string bytes by index through its own combinational port.

// Behaviour
// - the max power register holds upstream current in 2 mA counts.
// - that value covers hub silicon and board only, not an attached compound peripheral.
// - the power-on delay register holds port power-good time in 2 ms counts.
// - the language high register gives bits 15 to 8 of the language id.
// - the language low register gives bits 7 to 0 of the language id.
// - maker text occupies bytes 16h to 53h, 62 bytes.
// - item text occupies bytes 54h to 91h, one byte each.
// - serial number text occupies bytes 92h to CFh, one byte each.
// - a reset command or external reset returns every bank register to zero; only external reset clears the read data.
module hdc_regs (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic soft_reset_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic [7:0] bus_powered_power_value_o,
  output logic [7:0] port_power_on_delay_o,
  output logic [15:0] language_code_o,
  output logic [7:0] maker_text_length_value_o,
  output logic [7:0] item_text_length_value_o,
  output logic [7:0] serial_number_length_value_o,
  input wire logic [1:0] desc_sel_i,
  input wire logic [5:0] desc_idx_i,
  output logic [7:0] desc_byte_o
);
  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  // one flat array indexed by address minus the first offset
  logic [7:0] bank_ff [hdc_pkg::BANK_BYTES];
  logic [7:0] rd_ff;
  logic hit;
  logic [7:0] idx;
  logic [7:0] desc_addr;

  // byte positions of the single registers inside bank_ff
  localparam int POS_POWER = int'(hdc_pkg::ADDR_MAX_POWER - hdc_pkg::ADDR_MAX_POWER);
  localparam int POS_DELAY = int'(hdc_pkg::ADDR_PWR_ON_DELAY - hdc_pkg::ADDR_MAX_POWER);
  localparam int POS_LANG_HIGH = int'(hdc_pkg::ADDR_LANG_HIGH - hdc_pkg::ADDR_MAX_POWER);
  localparam int POS_LANG_LOW = int'(hdc_pkg::ADDR_LANG_LOW - hdc_pkg::ADDR_MAX_POWER);
  localparam int POS_MAKER_LEN = int'(hdc_pkg::ADDR_MAKER_LEN - hdc_pkg::ADDR_MAX_POWER);
  localparam int POS_ITEM_LEN = int'(hdc_pkg::ADDR_ITEM_LEN - hdc_pkg::ADDR_MAX_POWER);
  localparam int POS_SERIAL_LEN = int'(hdc_pkg::ADDR_SERIAL_LEN - hdc_pkg::ADDR_MAX_POWER);

  // --------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------
  // the flat array must reach the last serial byte, or high writes would fall off its end
  if (hdc_pkg::BANK_BYTES
      != int'(hdc_pkg::ADDR_SERIAL_LAST - hdc_pkg::ADDR_MAX_POWER) + 1) begin : g_bank_chk
    $error("bank size does not match the register map");
  end
  // each text holds two bytes per character
  if (hdc_pkg::STR_BYTES != 2 * hdc_pkg::MAX_CHARS) begin : g_text_chk
    $error("text size does not match the character limit");
  end
  // the descriptor index must be able to address every text byte
  if (hdc_pkg::STR_BYTES > (1 << hdc_pkg::STR_IDX_W)) begin : g_idx_chk
    $error("descriptor index too narrow for a text");
  end
  // the maker text span must equal the text size that bounds the shared index; item and serial spans are not checked
  if (int'(hdc_pkg::ADDR_MAKER_LAST - hdc_pkg::ADDR_MAKER_FIRST) + 1
      != hdc_pkg::STR_BYTES) begin : g_span_chk
    $error("maker text span does not match the text size");
  end

  assign hit = (addr_i >= hdc_pkg::ADDR_MAX_POWER) && (addr_i <= hdc_pkg::ADDR_SERIAL_LAST);
  assign idx = addr_i - hdc_pkg::ADDR_MAX_POWER;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < hdc_pkg::BANK_BYTES; i++) begin
        bank_ff[i] <= hdc_pkg::RESET_VALUE;
      end
    end else if (clk_en_i) begin
      if (soft_reset_i) begin
        for (int i = 0; i < hdc_pkg::BANK_BYTES; i++) begin
          bank_ff[i] <= hdc_pkg::RESET_VALUE;
        end
      end else if (wr_en_i && hit) begin
        // string ranges are plain bytes; pairing is the writer's job
        bank_ff[idx] <= wdata_i;
      end
    end
  end

  // --------------------------------------------------------------
  // register read port
  // --------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_ff <= hdc_pkg::RESET_VALUE;
    end else if (clk_en_i && rd_en_i) begin
      rd_ff <= hit ? bank_ff[idx] : hdc_pkg::UNMAPPED_READ;
    end
  end
  assign rdata_o = rd_ff;

  // --------------------------------------------------------------
  // descriptor side
  // --------------------------------------------------------------
  // lengths above 31 are passed on unchanged; clamping is left to software
  assign bus_powered_power_value_o = bank_ff[POS_POWER];
  assign port_power_on_delay_o = bank_ff[POS_DELAY];
  assign language_code_o = {bank_ff[POS_LANG_HIGH], bank_ff[POS_LANG_LOW]};
  assign maker_text_length_value_o = bank_ff[POS_MAKER_LEN];
  assign item_text_length_value_o = bank_ff[POS_ITEM_LEN];
  assign serial_number_length_value_o = bank_ff[POS_SERIAL_LEN];

  always_comb begin
    unique case (desc_sel_i)
      2'h1: desc_addr = hdc_pkg::ADDR_ITEM_FIRST;
      2'h2: desc_addr = hdc_pkg::ADDR_SERIAL_FIRST;
      default: desc_addr = hdc_pkg::ADDR_MAKER_FIRST;
    endcase
  end
  // out-of-range index reads zero rather than a neighbouring string
  assign desc_byte_o = (desc_idx_i < hdc_pkg::STR_IDX_W'(hdc_pkg::STR_BYTES))
      ? bank_ff[8'(desc_addr - hdc_pkg::ADDR_MAX_POWER + {2'h0, desc_idx_i})]
      : hdc_pkg::UNMAPPED_READ;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  soft_clear_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && soft_reset_i |=> language_code_o == 16'h0000 && port_power_on_delay_o == 8'h00)
    else $error("soft reset left a register set");
  lang_write_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && !soft_reset_i && wr_en_i && addr_i == hdc_pkg::ADDR_LANG_HIGH
    |=> language_code_o[15:8] == $past(wdata_i))
    else $error("language high byte not stored");
  lang_low_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && !soft_reset_i && wr_en_i && addr_i == hdc_pkg::ADDR_LANG_LOW
    |=> language_code_o[7:0] == $past(wdata_i))
    else $error("language low byte not stored");
  power_write_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && !soft_reset_i && wr_en_i && addr_i == hdc_pkg::ADDR_MAX_POWER
    |=> bus_powered_power_value_o == $past(wdata_i))
    else $error("max power not stored");
  delay_write_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && !soft_reset_i && wr_en_i && addr_i == hdc_pkg::ADDR_PWR_ON_DELAY
    |=> port_power_on_delay_o == $past(wdata_i))
    else $error("power-on delay not stored");
  item_first_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && !soft_reset_i && wr_en_i && addr_i == hdc_pkg::ADDR_ITEM_FIRST
    && desc_sel_i == 2'h1 && desc_idx_i == 6'h00 ##1 !(clk_en_i && (wr_en_i || soft_reset_i))
    && desc_sel_i == 2'h1 && desc_idx_i == 6'h00 |-> desc_byte_o == $past(wdata_i))
    else $error("item text first byte misplaced");
  unmapped_read_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && rd_en_i && addr_i > hdc_pkg::ADDR_SERIAL_LAST |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  freeze_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !clk_en_i |=> $stable(rdata_o) && $stable(language_code_o))
    else $error("state moved with clock enable low");
  maker_len_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && !soft_reset_i && wr_en_i && addr_i == hdc_pkg::ADDR_MAKER_LEN
    |=> maker_text_length_value_o == $past(wdata_i))
    else $error("maker text length not stored");
  item_len_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && !soft_reset_i && wr_en_i && addr_i == hdc_pkg::ADDR_ITEM_LEN
    |=> item_text_length_value_o == $past(wdata_i))
    else $error("item text length not stored");
  serial_len_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && !soft_reset_i && wr_en_i && addr_i == hdc_pkg::ADDR_SERIAL_LEN
    |=> serial_number_length_value_o == $past(wdata_i))
    else $error("serial text length not stored");
  soft_wins_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && soft_reset_i
    |=> bus_powered_power_value_o == hdc_pkg::RESET_VALUE
    && maker_text_length_value_o == hdc_pkg::RESET_VALUE
    && item_text_length_value_o == hdc_pkg::RESET_VALUE
    && serial_number_length_value_o == hdc_pkg::RESET_VALUE)
    else $error("soft reset did not clear the lengths");
  read_old_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && rd_en_i && addr_i == hdc_pkg::ADDR_LANG_LOW
    |=> rdata_o == $past(language_code_o[7:0]))
    else $error("read data does not match the stored byte");
  read_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    clk_en_i && !rd_en_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  desc_range_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    desc_idx_i > 6'(hdc_pkg::STR_BYTES - 1) |-> desc_byte_o == hdc_pkg::UNMAPPED_READ)
    else $error("descriptor index past the text end not zero");
  freeze_cfg_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !clk_en_i |=> $stable(bus_powered_power_value_o) && $stable(maker_text_length_value_o))
    else $error("settings moved with clock enable low");
endmodule

// ### shared/hdc_pkg.sv
// hdc_pkg: register map constants for the hub descriptor configuration bank.
// assumes: byte-wide register port, addresses as printed, all defaults zero.
package hdc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_MAX_POWER = 8'h0F;
  localparam logic [7:0] ADDR_PWR_ON_DELAY = 8'h10;
  localparam logic [7:0] ADDR_LANG_HIGH = 8'h11;
  localparam logic [7:0] ADDR_LANG_LOW = 8'h12;
  localparam logic [7:0] ADDR_MAKER_LEN = 8'h13;
  localparam logic [7:0] ADDR_ITEM_LEN = 8'h14;
  localparam logic [7:0] ADDR_SERIAL_LEN = 8'h15;
  localparam logic [7:0] ADDR_MAKER_FIRST = 8'h16;
  localparam logic [7:0] ADDR_MAKER_LAST = 8'h53;
  localparam logic [7:0] ADDR_ITEM_FIRST = 8'h54;
  localparam logic [7:0] ADDR_ITEM_LAST = 8'h91;
  localparam logic [7:0] ADDR_SERIAL_FIRST = 8'h92;
  localparam logic [7:0] ADDR_SERIAL_LAST = 8'hCF;
  localparam int STR_BYTES = 62;
  localparam int STR_IDX_W = 6;
  localparam int BANK_BYTES = 193;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int MAX_CHARS = 31;
  localparam int POWER_UNIT_MA = 2;
  localparam int DELAY_UNIT_MS = 2;
endpackage

// ### tb/hdc_cfg_master.sv
// hdc_cfg_master: configuration master model for the descriptor register port.
// assumes: requests are taken at rising edges and answered one cycle later.
module hdc_cfg_master (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic soft_reset_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_en_o, rd_en_o, soft_reset_o, addr_o, wdata_o} = '0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    {addr_o, wdata_o, wr_en_o} = {a, d, 1'b1};
    @(negedge mclk_i);
    {addr_o, wdata_o, wr_en_o} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk_i);
    {addr_o, rd_en_o} = {a, 1'b1};
    @(negedge mclk_i);
    {addr_o, rd_en_o} = {~a, 1'b0};
    v = rdata_i;
  endtask
  task automatic clear();
    @(negedge mclk_i);
    soft_reset_o = 1'b1;
    @(negedge mclk_i);
    soft_reset_o = 1'b0;
  endtask
endmodule

// ### tb/tb.sv
// tb: self-checking bench for the descriptor configuration bank.
// assumes: hdc_cfg_master drives the register port at falling edges.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, resetn_i = 0, wr, rd, srst;
  logic [7:0] addr, wdata, rdata, pwr, dly, mlen, ilen, slen, dbyte, v;
  logic [15:0] lang;
  logic [1:0] sel = 0;
  logic [5:0] idx = 0;
  logic en = 1;
  int failures = 0, comparisons = 0;
  logic [7:0] base [3] = '{8'h16, 8'h54, 8'h92};
  logic [7:0] cfg [7] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'h1F, 8'h01, 8'h1E};
  always #4 mclk_i = ~mclk_i;
  hdc_cfg_master mst (.mclk_i(mclk_i), .rdata_i(rdata), .wr_en_o(wr), .rd_en_o(rd),
    .soft_reset_o(srst), .addr_o(addr), .wdata_o(wdata));
  hdc_regs uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .clk_en_i(en), .soft_reset_i(srst),
    .wr_en_i(wr), .rd_en_i(rd), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .bus_powered_power_value_o(pwr), .port_power_on_delay_o(dly), .language_code_o(lang),
    .maker_text_length_value_o(mlen), .item_text_length_value_o(ilen),
    .serial_number_length_value_o(slen), .desc_sel_i(sel), .desc_idx_i(idx),
    .desc_byte_o(dbyte));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    summarize();
  end
  initial begin
    repeat (2) @(negedge mclk_i);
    resetn_i = 1;
    for (int a = 14; a < 24; a++) begin
      mst.rd(8'(a), v);
      chk(v, 0);
    end
    $display("test defaults done");
    // length values stay at or below 31 characters
    for (int i = 0; i < 7; i++) mst.wr(8'h0F + 8'(i), cfg[i]);
    chk(pwr, 8'hA0);
    chk(dly, 8'hA1);
    chk(lang, 16'hA2A3);
    chk({mlen, ilen, slen}, 24'h1F011E);
    for (int i = 0; i < 7; i++) begin
      mst.rd(8'h0F + 8'(i), v);
      chk(v, cfg[i]);
    end
    $display("test settings done");
    // one character low byte first, plus the last byte of each text
    sel = 2'h1;
    for (int s = 0; s < 3; s++) begin
      mst.wr(base[s], 8'h31 + 8'(s));
      mst.wr(base[s] + 8'd1, 8'h50 + 8'(s));
      mst.wr(base[s] + 8'd61, 8'hC0 + 8'(s));
    end
    for (int s = 0; s < 3; s++) begin
      sel = 2'(s);
      idx = 0;
      #1 chk(dbyte, 8'h31 + 8'(s));
      idx = 1;
      #1 chk(dbyte, 8'h50 + 8'(s));
      idx = 61;
      #1 chk(dbyte, 8'hC0 + 8'(s));
      idx = 62;
      #1 chk(dbyte, 8'h00);
      mst.rd(base[s] + 8'd61, v);
      chk(v, 8'hC0 + 8'(s));
    end
    mst.wr(8'h0E, 8'hFF);
    mst.wr(8'hD0, 8'hFF);
    mst.rd(8'hD0, v);
    chk(v, 0);
    $display("test strings done");
    mst.clear();
    chk({pwr, lang, slen}, 0);
    mst.rd(8'h92, v);
    chk(v, 0);
    en = 0;
    mst.wr(8'h0F, 8'h55);
    chk(pwr, 8'h00);
    en = 1;
    mst.wr(8'h11, 8'h09);
    chk(lang, 16'h0900);
    resetn_i = 0;
    @(negedge mclk_i);
    resetn_i = 1;
    chk(lang, 0);
    $display("test resets done");
    summarize();
  end
endmodule
